/* hw/fault_comparator.sv */
// Limit comparator with consecutive-fault queue, comparator/interrupt modes.
// Expects one conv_done pulse per finished conversion from the control side.
`timescale 1ns/1ps
`default_nettype none
module fault_comparator (
	input  wire logic clock_i,
	input  wire logic rst_i,
	tw_cmp_if.cmp     cmp
);
	logic       hi_phase;
	logic [2:0] count;
	logic       latched;
	logic       trip;
	logic       fire;
	logic [2:0] need;

	assign need = tw_pkg::fault_need(cmp.queue);
	// Watch the high limit until tripped, then the hysteresis limit
	assign trip = hi_phase ? ($signed(cmp.temp) > $signed(cmp.tos))
	                       : ($signed(cmp.temp) < $signed(cmp.hyst));
	assign fire = cmp.conv_done & trip & ((count + 3'h1) >= need);

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			count <= 3'h0;
		end else if (cmp.conv_done) begin
			if (!trip || fire) begin
				count <= 3'h0;
			end else begin
				count <= count + 3'h1;
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			hi_phase <= 1'b1;
		end else if (fire) begin
			hi_phase <= ~hi_phase;
		end
	end

	// A new event wins over a read or shutdown in the same cycle
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			latched <= 1'b0;
		end else if (fire && cmp.int_mode) begin
			latched <= 1'b1;
		end else if (cmp.int_mode && (cmp.read_evt || cmp.shutdown)) begin
			latched <= 1'b0;
		end
	end

	// Comparator mode follows the phase and is untouched by shutdown
	assign cmp.active = cmp.int_mode ? latched : ~hi_phase;
endmodule
`default_nettype wire

/* hw/pin_sync.sv */
// Two-flop synchronisers for the bus pins, plus edge and start/stop detect.
// Assumes the core clock is several times faster than the bus clock.
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
	input  wire logic clock_i,
	input  wire logic rst_i,
	input  wire logic scl_i,
	input  wire logic sda_i,
	output logic      sda_level_o,
	output logic      scl_rise_o,
	output logic      scl_fall_o,
	output logic      start_o,
	output logic      stop_o
);
	logic [1:0] meta;
	logic [1:0] sync;
	logic [1:0] prev;

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			meta <= 2'h3;
			sync <= 2'h3;
			prev <= 2'h3;
		end else begin
			meta <= {scl_i, sda_i};
			sync <= meta;
			prev <= sync;
		end
	end

	assign sda_level_o = sync[0];
	assign scl_rise_o  = sync[1] & ~prev[1];
	assign scl_fall_o  = ~sync[1] & prev[1];
	// Data edges while the clock stays high frame a transfer
	assign start_o     = sync[1] & prev[1] & prev[0] & ~sync[0];
	assign stop_o      = sync[1] & prev[1] & ~prev[0] & sync[0];
endmodule
`default_nettype wire

/* hw/thermal_watchdog.sv */
// Digital core of a temperature sensor with thermal watchdog and I2C slave.
// Assumes rst_i is the power-on reset and temp_sample_i comes from a
// converter front end in the same clock domain, valid when sampled.
`timescale 1ns/1ps
`default_nettype none
module thermal_watchdog #(
	parameter int unsigned TIMEOUT_CYC = tw_pkg::TIMEOUT_CYC,
	parameter int unsigned CONV_CYC    = tw_pkg::CONV_CYC,
	parameter logic [7:0]  ID_VALUE    = 8'h5C  // Arbitrary identity value
) (
	input  wire logic       clock_i,
	input  wire logic       rst_i,
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	input  wire logic [2:0] address_select_pins_i,
	input  wire logic [8:0] temp_sample_i,
	output logic            sda_o,
	output logic            sda_oe_o,
	output logic            os_o,
	output logic            os_oe_o,
	output logic            shutdown_o,
	output logic            conv_busy_o
);
	tw_cmp_if cmp_bus();

	logic                sda_s;
	logic                scl_rise;
	logic                scl_fall;
	logic                start;
	logic                stop;
	logic [2:0]          pins_s1;
	logic [2:0]          pins;
	tw_pkg::link_state_t state;
	logic [3:0]          cnt;
	logic [7:0]          sr;
	logic [1:0]          idx;
	logic                rw;
	logic                half;
	logic                busy;
	logic                wr_stb;
	logic                read_evt;
	logic                stuck;
	logic [31:0]         to_cnt;
	logic [31:0]         conv_cnt;
	logic                conv_done;
	logic [8:0]          temp_reg;
	logic [8:0]          tos;
	logic [8:0]          hyst;
	logic [4:0]          cfg;
	logic [2:0]          ptr;
	logic                load_tx;
	logic [7:0]          next_byte;
	logic                addr_hit;

	pin_sync u_sync (
		.clock_i     (clock_i),
		.rst_i       (rst_i),
		.scl_i       (scl_i),
		.sda_i       (sda_i),
		.sda_level_o (sda_s),
		.scl_rise_o  (scl_rise),
		.scl_fall_o  (scl_fall),
		.start_o     (start),
		.stop_o      (stop)
	);

	fault_comparator u_cmp (
		.clock_i (clock_i),
		.rst_i   (rst_i),
		.cmp     (cmp_bus)
	);

	assign cmp_bus.conv_done = conv_done;
	assign cmp_bus.temp      = temp_reg;
	assign cmp_bus.tos       = tos;
	assign cmp_bus.hyst      = hyst;
	assign cmp_bus.int_mode  = cfg[tw_pkg::CFG_INT];
	assign cmp_bus.shutdown  = cfg[tw_pkg::CFG_SD];
	assign cmp_bus.queue     = cfg[tw_pkg::CFG_QHI:tw_pkg::CFG_QLO];
	assign cmp_bus.read_evt  = read_evt;

	// Register byte served for a pointer; half selects the second byte of temp, hyst and tos
	function automatic logic [7:0] read_byte(
		input logic [2:0] sel,
		input logic       second,
		input logic [8:0] t,
		input logic [8:0] h,
		input logic [8:0] o,
		input logic [4:0] c
	);
		logic [8:0] word;
		word = 9'h000;
		case (sel)
			tw_pkg::PTR_TEMP: word = t;
			tw_pkg::PTR_HYST: word = h;
			tw_pkg::PTR_TOS:  word = o;
			default:          word = 9'h000;
		endcase
		case (sel)
			tw_pkg::PTR_CFG: read_byte = {3'h0, c};
			tw_pkg::PTR_ID:  read_byte = ID_VALUE;
			default:         read_byte = second ? {word[0], 7'h00} : word[8:1];
		endcase
	endfunction

	// Select pins are straps from outside; sample them twice
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			pins_s1 <= 3'h0;
			pins    <= 3'h0;
		end else begin
			pins_s1 <= address_select_pins_i;
			pins    <= pins_s1;
		end
	end

	assign addr_hit  = (sr[7:1] == {tw_pkg::ADDR_HI, pins});
	assign next_byte = read_byte(ptr, half, temp_reg, hyst, tos, cfg);
	assign load_tx   = scl_fall && ((state == tw_pkg::ST_ACK && rw) || state == tw_pkg::ST_TXACK);

	// Serial link: receive, acknowledge and transmit bytes
	always_ff @(posedge clock_i) begin
		wr_stb   <= 1'b0;
		read_evt <= 1'b0;
		if (rst_i || stuck) begin
			state    <= tw_pkg::ST_IDLE;
			sda_oe_o <= 1'b0;
			cnt      <= 4'h0;
			sr       <= 8'h00;
			idx      <= tw_pkg::IDX_ADDR;
			rw       <= 1'b0;
			half     <= 1'b0;
			busy     <= 1'b0;
		end else if (start) begin
			state    <= tw_pkg::ST_RX;
			sda_oe_o <= 1'b0;
			cnt      <= 4'h0;
			idx      <= tw_pkg::IDX_ADDR;
			half     <= 1'b0;
		end else if (stop) begin
			state    <= tw_pkg::ST_IDLE;
			sda_oe_o <= 1'b0;
			busy     <= 1'b0;
		end else if (load_tx) begin
			sr       <= {next_byte[6:0], 1'b0};
			sda_oe_o <= ~next_byte[7];
			cnt      <= 4'h1;
			state    <= tw_pkg::ST_TX;
		end else begin
			case (state)
				tw_pkg::ST_RX: begin
					if (scl_rise && cnt != tw_pkg::BITS_BYTE) begin
						sr  <= {sr[6:0], sda_s};
						cnt <= cnt + 4'h1;
					end else if (scl_fall && cnt == tw_pkg::BITS_BYTE) begin
						if (idx == tw_pkg::IDX_ADDR && !addr_hit) begin
							state <= tw_pkg::ST_IDLE;
						end else begin
							state    <= tw_pkg::ST_ACK;
							sda_oe_o <= 1'b1;
							if (idx == tw_pkg::IDX_ADDR) begin
								rw       <= sr[0];
								busy     <= 1'b1;
								read_evt <= sr[0];
							end else begin
								wr_stb <= 1'b1;
							end
						end
					end
				end
				tw_pkg::ST_ACK: begin
					if (scl_fall) begin
						sda_oe_o <= 1'b0;
						state    <= tw_pkg::ST_RX;
						cnt      <= 4'h0;
						if (idx != tw_pkg::IDX_LSB) begin
							idx <= idx + 2'h1;
						end
					end
				end
				tw_pkg::ST_TX: begin
					if (scl_fall) begin
						if (cnt == tw_pkg::BITS_BYTE) begin
							sda_oe_o <= 1'b0;
							state    <= tw_pkg::ST_TXACK;
							half     <= ~half;
						end else begin
							sda_oe_o <= ~sr[7];
							sr       <= {sr[6:0], 1'b0};
							cnt      <= cnt + 4'h1;
						end
					end
				end
				tw_pkg::ST_TXACK: begin
					// Nack ends the read quietly; ack continues with the next byte
					if (scl_rise && sda_s) begin
						state <= tw_pkg::ST_IDLE;
					end
				end
				default: begin
					state <= tw_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Pointer and writable registers; bytes land as they are acknowledged
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			ptr  <= tw_pkg::PTR_RST;
			cfg  <= tw_pkg::CFG_RST;
			tos  <= tw_pkg::TOS_RST;
			hyst <= tw_pkg::HYST_RST;
		end else if (wr_stb) begin
			if (idx == tw_pkg::IDX_PTR) begin
				ptr <= sr[2:0];
			end else begin
				case (ptr)
					tw_pkg::PTR_CFG: begin
						if (idx == tw_pkg::IDX_MSB) begin
							cfg <= sr[4:0];
						end
					end
					tw_pkg::PTR_HYST: begin
						if (idx == tw_pkg::IDX_MSB) begin
							hyst[8:1] <= sr;
						end else begin
							hyst[0] <= sr[7];
						end
					end
					tw_pkg::PTR_TOS: begin
						if (idx == tw_pkg::IDX_MSB) begin
							tos[8:1] <= sr;
						end else begin
							tos[0] <= sr[7];
						end
					end
					default: begin
						tos <= tos;
					end
				endcase
			end
		end
	end

	// Stuck data line watchdog, off in shutdown
	always_ff @(posedge clock_i) begin
		if (rst_i || cfg[tw_pkg::CFG_SD] || sda_s) begin
			to_cnt <= 32'h0000_0000;
			stuck  <= 1'b0;
		end else if (to_cnt == TIMEOUT_CYC - 1) begin
			to_cnt <= 32'h0000_0000;
			stuck  <= 1'b1;
		end else begin
			to_cnt <= to_cnt + 32'h0000_0001;
			stuck  <= 1'b0;
		end
	end

	// Conversion timebase; any transaction to us restarts it from zero
	always_ff @(posedge clock_i) begin
		if (rst_i || cfg[tw_pkg::CFG_SD] || busy) begin
			conv_cnt  <= 32'h0000_0000;
			conv_done <= 1'b0;
		end else if (conv_cnt == CONV_CYC - 1) begin
			conv_cnt  <= 32'h0000_0000;
			conv_done <= 1'b1;
		end else begin
			conv_cnt  <= conv_cnt + 32'h0000_0001;
			conv_done <= 1'b0;
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			temp_reg <= 9'h000;
		end else if (conv_cnt == CONV_CYC - 1) begin
			temp_reg <= temp_sample_i;
		end
	end

	// Open-drain pins only ever pull low
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			sda_o       <= 1'b0;
			os_o        <= 1'b0;
			os_oe_o     <= 1'b0;
			shutdown_o  <= 1'b0;
			conv_busy_o <= 1'b0;
		end else begin
			sda_o       <= 1'b0;
			os_o        <= 1'b0;
			os_oe_o     <= cmp_bus.active ^ cfg[tw_pkg::CFG_POL];
			shutdown_o  <= cfg[tw_pkg::CFG_SD];
			conv_busy_o <= ~cfg[tw_pkg::CFG_SD] & ~busy;
		end
	end
endmodule
`default_nettype wire

/* pkg/tw_cmp_if.sv */
// Carrier between the bus/register side and the fault comparator.
// All signals live in the core clock domain.
`timescale 1ns/1ps
`default_nettype none
interface tw_cmp_if;
	logic       conv_done;
	logic [8:0] temp;
	logic [8:0] tos;
	logic [8:0] hyst;
	logic       int_mode;
	logic       shutdown;
	logic [1:0] queue;
	logic       read_evt;
	logic       active;
	modport ctrl(output conv_done, temp, tos, hyst, int_mode, shutdown, queue, read_evt, input active);
	modport cmp(input conv_done, temp, tos, hyst, int_mode, shutdown, queue, read_evt, output active);
endinterface
`default_nettype wire

/* pkg/tw_pkg.sv */
// Shared constants and types of the thermal watchdog sensor.
// Assumes a 25 MHz core clock; counts are derived from it here.
`default_nettype none
package tw_pkg;
	localparam int unsigned CLK_KHZ     = 25000;
	localparam int unsigned TIMEOUT_MS  = 75;
	localparam int unsigned TIMEOUT_CYC = CLK_KHZ * TIMEOUT_MS;
	localparam int unsigned CONV_MS     = 100;
	localparam int unsigned CONV_CYC    = CLK_KHZ * CONV_MS;
	localparam logic [3:0] ADDR_HI      = 4'h9;
	localparam logic [2:0] PTR_TEMP     = 3'h0;
	localparam logic [2:0] PTR_CFG      = 3'h1;
	localparam logic [2:0] PTR_HYST     = 3'h2;
	localparam logic [2:0] PTR_TOS      = 3'h3;
	localparam logic [2:0] PTR_ID       = 3'h7;
	localparam logic [2:0] PTR_RST      = 3'h0;
	localparam int unsigned CFG_SD      = 0;
	localparam int unsigned CFG_INT     = 1;
	localparam int unsigned CFG_POL     = 2;
	localparam int unsigned CFG_QLO     = 3;
	localparam int unsigned CFG_QHI     = 4;
	localparam logic [4:0] CFG_RST      = 5'h00;
	localparam logic [8:0] TOS_RST      = 9'h0A0;
	localparam logic [8:0] HYST_RST     = 9'h096;
	localparam logic [3:0] BITS_BYTE    = 4'h8;
	localparam logic [1:0] IDX_ADDR     = 2'h0;
	localparam logic [1:0] IDX_PTR      = 2'h1;
	localparam logic [1:0] IDX_MSB      = 2'h2;
	localparam logic [1:0] IDX_LSB      = 2'h3;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_RX    = 3'b001,
		ST_ACK   = 3'b010,
		ST_TX    = 3'b011,
		ST_TXACK = 3'b100
	} link_state_t;

	function automatic logic [2:0] fault_need(input logic [1:0] code);
		case (code)
			2'h0:    fault_need = 3'h1;
			2'h1:    fault_need = 3'h2;
			2'h2:    fault_need = 3'h4;
			default: fault_need = 3'h6;
		endcase
	endfunction
endpackage
`default_nettype wire

/* test/thermal_watchdog_bench.sv */
// Self-checking bench of the sensor core with a bus master model.
// Assumes shortened timeout and conversion counts.
`timescale 1ns/1ps
`default_nettype none
module thermal_watchdog_bench;
	localparam int unsigned TO = 200;
	localparam int unsigned CV = 300;
	localparam logic [7:0]  ID = 8'h3A;  // Arbitrary identity value
	typedef struct packed {logic [2:0] p; logic wr; logic [1:0] n; logic [15:0] wd; logic [15:0] ex;} row_t;
	logic        clock_i = 1'b0;
	logic        rst_i   = 1'b1;
	logic [2:0]  pins    = 3'h5;
	logic [8:0]  temp    = 9'h000;
	logic        scl;
	logic        sda_m;
	wire logic   sda_line;
	logic        sda_o, sda_oe_o, os_o, os_oe_o, shutdown_o, conv_busy_o;
	logic [15:0] rd;
	logic [7:0]  b;
	int          n;
	int          error_cnt    = 0;
	int          total_checks = 0;
	row_t        rows [8] = '{
		'{3'h3, 1'b0, 2'h0, 16'h0000, 16'h5000}, '{3'h2, 1'b0, 2'h0, 16'h0000, 16'h4B00},
		'{3'h1, 1'b0, 2'h0, 16'h0000, 16'h0000}, '{3'h7, 1'b1, 2'h1, 16'h0000, {ID, ID}},
		'{3'h3, 1'b1, 2'h2, 16'h1980, 16'h1980}, '{3'h2, 1'b1, 2'h2, 16'hFF80, 16'hFF80},
		'{3'h1, 1'b1, 2'h1, 16'hE000, 16'h0000}, '{3'h5, 1'b0, 2'h0, 16'h0000, 16'h0000}};
	always #20 clock_i = ~clock_i;
	assign sda_line = sda_m & ~sda_oe_o;
	tw_master #(.ADDR(7'h4D)) tw_master_i (.clock_i(clock_i), .sda_line_i(sda_line), .scl_o(scl), .sda_o(sda_m));
	thermal_watchdog #(.TIMEOUT_CYC(TO), .CONV_CYC(CV), .ID_VALUE(ID)) thermal_watchdog_i (
		.clock_i(clock_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda_line), .address_select_pins_i(pins),
		.temp_sample_i(temp), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .os_o(os_o), .os_oe_o(os_oe_o),
		.shutdown_o(shutdown_o), .conv_busy_o(conv_busy_o));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// One conversion with temperature t, then the output state
	task automatic conv(input logic [8:0] t, input logic e);
		@(posedge clock_i);
		temp <= t;
		repeat (CV - 1) @(posedge clock_i);
		#1;
		chk(16'(os_oe_o), 16'(e));
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		repeat (90000) @(posedge clock_i);
		error_cnt++;
		$display("MISMATCH t=%0t watchdog expired", $time);
		final_report();
	end
	initial begin
		repeat (2) @(posedge clock_i);
		rst_i <= 1'b0;
		tw_master_i.w(4);
		foreach (rows[i]) begin
			if (rows[i].wr) tw_master_i.write_reg(rows[i].p, rows[i].n, rows[i].wd);
			tw_master_i.read_reg(1'b1, rows[i].p, rd);
			chk(rd, rows[i].ex);
		end
		tw_master_i.read_reg(1'b1, 3'h3, rd);
		tw_master_i.read_reg(1'b0, 3'h0, rd);
		chk(rd, 16'h1980);
		$display("test registers done");
		for (int k = 0; k < 8; k++) begin
			tw_master_i.start();
			tw_master_i.xbyte({4'h9, 3'(k), 1'b0}, 1'b1, b);
			tw_master_i.stop();
			chk(16'(tw_master_i.last_ack), 16'(k == 5));
		end
		temp <= 9'h032;
		tw_master_i.w(CV + 20);
		tw_master_i.read_reg(1'b1, 3'h0, rd);
		chk(rd, 16'h1900);
		temp <= 9'h064;
		repeat (3) begin
			tw_master_i.w(CV / 2);
			tw_master_i.read_reg(1'b0, 3'h0, rd);
		end
		chk(rd, 16'h1900);
		tw_master_i.w(CV + 20);
		tw_master_i.read_reg(1'b0, 3'h0, rd);
		chk(rd, 16'h3200);
		$display("test conversion done");
		for (int q = 0; q < 4; q++) begin
			n = (q == 0) ? 1 : 2 * q;
			tw_master_i.write_reg(3'h1, 2'h1, {3'h0, 2'(q), 11'h000});
			tw_master_i.w(CV / 2);
			if (q == 1) begin
				conv(9'h040, 1'b0);
				conv(9'h000, 1'b0);
			end
			for (int j = 1; j <= n; j++) conv(9'h040, j == n);
			for (int j = 1; j <= n; j++) conv(9'h1FC, j != n);
		end
		tw_master_i.write_reg(3'h1, 2'h1, 16'h0400);
		tw_master_i.w(CV / 2);
		#1;
		chk(16'(os_oe_o), 16'h0001);
		conv(9'h040, 1'b0);
		conv(9'h1FC, 1'b1);
		$display("test comparator done");
		tw_master_i.write_reg(3'h1, 2'h1, 16'h0200);
		tw_master_i.w(CV / 2);
		conv(9'h040, 1'b1);
		conv(9'h040, 1'b1);
		tw_master_i.read_reg(1'b0, 3'h0, rd);
		#1;
		chk(16'(os_oe_o), 16'h0000);
		tw_master_i.w(CV / 2);
		conv(9'h040, 1'b0);
		conv(9'h1FC, 1'b1);
		tw_master_i.write_reg(3'h1, 2'h1, 16'h0300);
		#1;
		chk(16'({os_oe_o, shutdown_o}), 16'h0001);
		tw_master_i.write_reg(3'h3, 2'h2, 16'h1A00);
		tw_master_i.read_reg(1'b1, 3'h3, rd);
		chk(rd, 16'h1A00);
		$display("test interrupt done");
		tw_master_i.stall(TO + 40);
		#1;
		chk(16'(sda_oe_o), 16'h0001);
		rst_i <= 1'b1;
		tw_master_i.w(2);
		rst_i <= 1'b0;
		tw_master_i.stop();
		tw_master_i.w(CV + 20);
		tw_master_i.read_reg(1'b0, 3'h0, rd);
		chk(rd, 16'hFE00);
		tw_master_i.read_reg(1'b1, 3'h3, rd);
		chk(rd, 16'h5000);
		tw_master_i.stall(TO - 20);
		#1;
		chk(16'(sda_oe_o), 16'h0001);
		tw_master_i.w(40);
		#1;
		chk(16'(sda_oe_o), 16'h0000);
		tw_master_i.stop();
		$display("test timeout done");
		final_report();
	end
endmodule
`default_nettype wire

/* test/thermal_watchdog_props.sv */
// Pin-level checks of the sensor core.
// Assumes one core clock domain; attached by the bind at the foot.
`timescale 1ns/1ps
`default_nettype none
module thermal_watchdog_props #(
	parameter int unsigned TIMEOUT_CYC = 200
) (
	input  wire logic       clock_i,
	input  wire logic       rst_i,
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	input  wire logic [2:0] address_select_pins_i,
	input  wire logic [8:0] temp_sample_i,
	input  wire logic       sda_o,
	input  wire logic       sda_oe_o,
	input  wire logic       os_o,
	input  wire logic       os_oe_o,
	input  wire logic       shutdown_o,
	input  wire logic       conv_busy_o
);
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (rst_i);
	logic [31:0] low_cnt;
	// Pin-level low time; margin covers the input synchronisers
	always_ff @(posedge clock_i) begin
		if (rst_i || sda_i || shutdown_o) begin
			low_cnt <= 32'h0000_0000;
		end else if (low_cnt < 32'h0001_0000) begin
			low_cnt <= low_cnt + 32'h0000_0001;
		end
	end
	sequence s_stop;
		scl_i && $rose(sda_i);
	endsequence
	sequence s_acking;
		sda_oe_o [*2];
	endsequence
	property p_rst;
		$fell(rst_i) |-> !(os_oe_o || sda_oe_o || shutdown_o || conv_busy_o);
	endproperty
	a_rst: assert property (p_rst) else $error("outputs busy after reset");
	property p_pins;
		sda_o == 1'b0 && os_o == 1'b0;
	endproperty
	a_pins: assert property (p_pins) else $error("open-drain pin driven high");
	property p_ack_conv;
		s_acking |-> !conv_busy_o;
	endproperty
	a_ack_conv: assert property (p_ack_conv) else $error("conversion runs in transfer");
	property p_restart;
		s_stop ##0 !shutdown_o |-> ##[1:8] conv_busy_o;
	endproperty
	a_restart: assert property (p_restart) else $error("no conversion after stop");
	property p_sd_idle;
		shutdown_o [*2] |-> !conv_busy_o;
	endproperty
	a_sd_idle: assert property (p_sd_idle) else $error("conversion in shutdown");
	property p_sd_chg;
		$changed(shutdown_o) |-> !conv_busy_o;
	endproperty
	a_sd_chg: assert property (p_sd_chg) else $error("shutdown changed off the bus");
	property p_oe_scl;
		$changed(sda_oe_o) |-> !scl_i && !$past(scl_i, 3);
	endproperty
	a_oe_scl: assert property (p_oe_scl) else $error("data moved while clock high");
	property p_timeout;
		low_cnt > 32'(TIMEOUT_CYC + 8) |-> !sda_oe_o;
	endproperty
	a_timeout: assert property (p_timeout) else $error("stuck data line kept low");
endmodule
bind thermal_watchdog thermal_watchdog_props #(
	.TIMEOUT_CYC(TIMEOUT_CYC)
) thermal_watchdog_props_i (
	.clock_i(clock_i),
	.rst_i(rst_i),
	.scl_i(scl_i),
	.sda_i(sda_i),
	.address_select_pins_i(address_select_pins_i),
	.temp_sample_i(temp_sample_i),
	.sda_o(sda_o),
	.sda_oe_o(sda_oe_o),
	.os_o(os_o),
	.os_oe_o(os_oe_o),
	.shutdown_o(shutdown_o),
	.conv_busy_o(conv_busy_o)
);
`default_nettype wire

/* test/tw_master.sv */
// Bus master model, 8 core cycles a bit (low 5, high 3).
// Assumes the bench resolves the data wire with a pull-up.
`timescale 1ns/1ps
`default_nettype none
module tw_master #(
	parameter logic [6:0] ADDR = 7'h4D
) (
	input  wire logic clock_i,
	input  wire logic sda_line_i,
	output logic      scl_o,
	output logic      sda_o
);
	logic last_ack;
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	task automatic w(input int n);
		repeat (n) @(posedge clock_i);
	endtask
	// Also used as repeated start
	task automatic start();
		@(posedge clock_i);
		scl_o <= 1'b0;
		w(2);
		sda_o <= 1'b1;
		w(3);
		scl_o <= 1'b1;
		w(3);
		sda_o <= 1'b0;
		w(3);
	endtask
	task automatic stop();
		@(posedge clock_i);
		scl_o <= 1'b0;
		w(2);
		sda_o <= 1'b0;
		w(3);
		scl_o <= 1'b1;
		w(3);
		sda_o <= 1'b1;
		w(4);
	endtask
	// Clock low 5 cycles, high 3; data read mid-high, well after the slave moved it
	task automatic bit_io(input logic v, output logic r);
		@(posedge clock_i);
		scl_o <= 1'b0;
		w(2);
		sda_o <= v;
		w(3);
		scl_o <= 1'b1;
		w(1);
		r = sda_line_i;
		w(1);
	endtask
	task automatic xbyte(input logic [7:0] d, input logic ack_in, output logic [7:0] q);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);
			q[i] = r;
		end
		bit_io(ack_in, r);
		last_ack = ~r;
	endtask
	// Address, pointer, then data bytes
	task automatic write_reg(input logic [2:0] p, input logic [1:0] n, input logic [15:0] d);
		logic [7:0] q;
		start();
		xbyte({ADDR, 1'b0}, 1'b1, q);
		xbyte({5'h00, p}, 1'b1, q);
		for (int i = 0; i < n; i++) xbyte(d[15 - 8 * i -: 8], 1'b1, q);
		stop();
	endtask
	// Preset pointer or pointer then repeated start
	task automatic read_reg(input logic set, input logic [2:0] p, output logic [15:0] d);
		logic [7:0] q;
		start();
		if (set) begin
			xbyte({ADDR, 1'b0}, 1'b1, q);
			xbyte({5'h00, p}, 1'b1, q);
			start();
		end
		xbyte({ADDR, 1'b1}, 1'b1, q);
		xbyte(8'hFF, 1'b0, d[15:8]);
		xbyte(8'hFF, 1'b1, d[7:0]);
		stop();
	endtask
	// Address byte, then the clock is held low through the ack
	task automatic stall(input int n);
		logic       r;
		logic [7:0] wa;
		wa = {ADDR, 1'b0};
		start();
		for (int i = 7; i >= 0; i--) bit_io(wa[i], r);
		@(posedge clock_i);
		scl_o <= 1'b0;
		w(2);
		sda_o <= 1'b1;
		w(n);
	endtask
endmodule
`default_nettype wire
